// [verilog/sfl_defs.vh]
/*
 * Constants of the speed and field loop controller: register offsets,
 * control bit positions, reset values and fixed-point scaling.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef SFL_DEFS_VH
`define SFL_DEFS_VH

// register byte offsets
`define SFL_CTRL 8'h00
`define SFL_SPD_GAIN 8'h04
`define SFL_DIDT 8'h08
`define SFL_FLD_GAIN 8'h0C
`define SFL_FLD_SETP 8'h10
`define SFL_MIN_FLD 8'h14
`define SFL_MAX_VOLTS 8'h18
`define SFL_EMF 8'h1C
`define SFL_BEMF_FBK 8'h20
`define SFL_VRATIO 8'h24
`define SFL_QDELAY 8'h28
`define SFL_OC_LIMIT 8'h2C
`define SFL_ST_DEMAND 8'h30
`define SFL_ST_FIELD 8'h34
`define SFL_ST_PERIOD 8'h38

// control bits
`define SFL_B_COMBINED 0
`define SFL_B_ARMV_FB 1
`define SFL_B_FW_EN 2
`define SFL_B_VMODE 3
`define SFL_B_QUENCH 4
`define SFL_B_FLD_EN 5

// 100 % of full_load_current or of rated field / voltage
`define SFL_FULL 16'h1000

// reset values
`define SFL_CTRL_RST 6'h25
`define SFL_SPD_KP_RST 16'h0400
`define SFL_SPD_TAU_RST 5'h06
`define SFL_DIDT_RST 16'h059A
`define SFL_FLD_KP_RST 16'h0100
`define SFL_FLD_TAU_RST 5'h03
`define SFL_FLD_SETP_RST 16'h1000
`define SFL_MIN_FLD_RST 16'h019A
`define SFL_MAX_VOLTS_RST 16'h1000
`define SFL_EMF_GAIN_RST 16'h01E0
`define SFL_EMF_LEAD_RST 8'h0D
`define SFL_EMF_LAG_RST 5'h09
`define SFL_BEMF_GAIN_RST 16'h0010
`define SFL_BEMF_LEAD_RST 8'hFF
`define SFL_BEMF_LAG_RST 5'h03
`define SFL_VRATIO_RST 8'hE6
`define SFL_QDELAY_RST 16'h01F4
`define SFL_OC_LIMIT_RST 16'h1333

// firing commands per mains cycle
`define SFL_ARM_SLOTS 3'h6
`define SFL_FLD_SLOTS 3'h2

`endif

// [verilog/sfl_leadlag.v]
/*
 * Lead/lag stage gain*(1+sT1)/(1+sT2), run once per enable tick.
 * Assumes x and the settings are on ref_clk; lag is a first-order
 * filter of 2**lag_sh ticks, lead is given as the ratio T1/T2 in Q8.
 */
`timescale 1ns/1ps
module sfl_leadlag #(
    parameter GAIN_SH = 4
) (
    input wire ref_clk,
    input wire rst,
    input wire en,
    input wire signed [15:0] x,
    input wire [15:0] gain,
    input wire [7:0] lead,
    input wire [4:0] lag_sh,
    output reg signed [15:0] y
);
    reg signed [23:0] s;
    wire signed [24:0] d = {x[15], x, 8'h00} - {s[23], s};
    wire signed [41:0] ld = d * $signed({1'b0, lead});
    wire signed [41:0] e = $signed({{18{s[23]}}, s}) + (ld >>> 8);
    wire signed [58:0] m = (e >>> 8) * $signed({1'b0, gain});
    wire signed [58:0] ms = m >>> GAIN_SH;
    wire signed [24:0] step = d >>> lag_sh;

    always @(posedge ref_clk) begin
        if (rst) begin
            s <= 24'h000000;
            y <= 16'h0000;
        end else if (en) begin
            s <= s + step[23:0];
            if (ms > 59'sd32767)
                y <= 16'h7FFF;
            else if (ms < -59'sd32768)
                y <= 16'h8000;
            else
                y <= ms[15:0];
        end
    end
endmodule

// [verilog/sfl_ctrl.v]
/*
 * Speed and field loop controller: speed PI with demand rate limit,
 * field PI or open-loop field voltage, field weakening lead/lag with
 * feedback lead/lag, standby/quench field timer and mains-locked
 * firing of the armature and field bridges. APB register slave.
 * Assumes feedback and demand inputs are on ref_clk; mains_zc is an
 * asynchronous pin high during the positive mains half cycle.
 */
`timescale 1ns/1ps
`include "sfl_defs.vh"
module sfl_ctrl #(
    parameter PW = 21
) (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire mains_zc,
    input wire signed [15:0] speed_demand,
    input wire signed [15:0] speed_fb,
    input wire signed [15:0] tacho_fb,
    input wire signed [15:0] enc_fb,
    input wire signed [15:0] arm_volts_fb,
    input wire signed [15:0] fld_cur_fb,
    input wire arm_quenched,
    input wire [7:0] arm_angle,
    output reg signed [15:0] cur_demand,
    output reg arm_fire,
    output reg fld_fire,
    output reg fld_oc_alarm
);
    function signed [15:0] sat;
        input signed [40:0] a;
        begin
            if (a > 41'sd32767)
                sat = 16'h7FFF;
            else if (a < -41'sd32768)
                sat = 16'h8000;
            else
                sat = a[15:0];
        end
    endfunction

    // registers
    reg [5:0] ctrl;
    reg [15:0] spd_kp;
    reg [4:0] spd_tau;
    reg [15:0] didt;
    reg [15:0] fld_kp;
    reg [4:0] fld_tau;
    reg [15:0] fld_setp;
    reg [15:0] min_fld;
    reg [15:0] max_volts;
    reg [15:0] emf_gain;
    reg [7:0] emf_lead;
    reg [4:0] emf_lag;
    reg [15:0] bemf_gain;
    reg [7:0] bemf_lead;
    reg [4:0] bemf_lag;
    reg [7:0] vratio;
    reg [15:0] qdelay;
    reg [15:0] oc_limit;

    wire combined = ctrl[`SFL_B_COMBINED];
    wire armv_fb = ctrl[`SFL_B_ARMV_FB];
    wire fw_en = ctrl[`SFL_B_FW_EN];
    wire vmode = ctrl[`SFL_B_VMODE];
    wire qmode = ctrl[`SFL_B_QUENCH];
    wire fld_en = ctrl[`SFL_B_FLD_EN];

    // mains zero-cross synchroniser and period measurement
    reg zc_s1;
    reg zc_s2;
    reg zc_d;
    reg zc_seen;
    reg [PW-1:0] pcnt;
    reg [PW-1:0] period;
    wire zc_edge = zc_s2 & ~zc_d;

    always @(posedge ref_clk) begin
        if (rst) begin
            zc_s1 <= 1'b0;
            zc_s2 <= 1'b0;
            zc_d <= 1'b0;
            zc_seen <= 1'b0;
            pcnt <= {PW{1'b0}};
            period <= {PW{1'b1}};
        end else begin
            zc_s1 <= mains_zc;
            zc_s2 <= zc_s1;
            zc_d <= zc_s2;
            if (zc_edge) begin
                // first cross only starts the count; a partial cycle is never locked
                pcnt <= {{PW-1{1'b0}}, 1'b1};
                zc_seen <= 1'b1;
                if (zc_seen)
                    period <= pcnt;
            end else if (pcnt != {PW{1'b1}}) begin
                pcnt <= pcnt + 1'b1;
            end
        end
    end

    // firing channels: 0 armature (6 slots), 1 field (2 slots)
    reg [7:0] fld_angle;
    reg fld_off;
    wire [1:0] tick;
    wire [1:0] fire;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            reg [PW-1:0] acc;
            reg fired;
            reg tk;
            reg fr;
            wire [2:0] slots = (g == 0) ? `SFL_ARM_SLOTS : `SFL_FLD_SLOTS;
            wire [7:0] ang = (g == 0) ? arm_angle : fld_angle;
            wire [PW+7:0] thr_p = ang * period;
            wire [PW-1:0] thr = thr_p[PW+7:8];
            wire [PW:0] nxt = {1'b0, acc} + {{PW-2{1'b0}}, slots};
            assign tick[g] = tk;
            assign fire[g] = fr;
            always @(posedge ref_clk) begin
                if (rst) begin
                    acc <= {PW{1'b0}};
                    fired <= 1'b0;
                    tk <= 1'b0;
                    fr <= 1'b0;
                end else begin
                    fr <= 1'b0;
                    tk <= 1'b0;
                    if (zc_edge) begin
                        // lock slot phase to the zero cross
                        acc <= {PW{1'b0}};
                        fired <= 1'b0;
                        tk <= 1'b1;
                    end else if (nxt >= {1'b0, period}) begin
                        acc <= nxt[PW-1:0] - period;
                        fired <= 1'b0;
                        tk <= 1'b1;
                    end else begin
                        acc <= nxt[PW-1:0];
                        if (!fired && acc >= thr) begin
                            fired <= 1'b1;
                            fr <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate
    wire arm_tick = tick[0];
    wire fld_tick = tick[1];

    // speed loop
    wire signed [15:0] fb_p = combined ? tacho_fb : speed_fb;
    wire signed [15:0] fb_i = combined ? enc_fb : speed_fb;
    wire signed [15:0] err_p = sat(speed_demand - fb_p);
    wire signed [15:0] err_i = sat(speed_demand - fb_i);
    wire signed [32:0] sp_prod = err_p * $signed({1'b0, spd_kp});
    wire signed [32:0] si_prod = err_i * $signed({1'b0, spd_kp});
    reg signed [23:0] spd_int;
    wire signed [40:0] spd_int_n = {{17{spd_int[23]}}, spd_int}
        + {{8{si_prod[32]}}, si_prod >>> spd_tau};
    wire signed [15:0] spd_i = spd_int[23:8];
    wire signed [15:0] spd_p = sat($signed({{8{sp_prod[32]}}, sp_prod}) >>> 8);
    wire signed [15:0] spd_out = sat(spd_p + spd_i);
    wire signed [16:0] ddelta = spd_out - cur_demand;
    wire signed [16:0] dlim = {1'b0, didt};

    always @(posedge ref_clk) begin
        if (rst) begin
            spd_int <= 24'h000000;
            cur_demand <= 16'h0000;
        end else begin
            if (arm_quenched)
                spd_int <= 24'h000000;
            else if (arm_tick)
                spd_int <= {sat(spd_int_n >>> 8), 8'h00};
            // refreshed on each slot tick, just ahead of the current run
            if (arm_tick) begin
                if (ddelta > dlim)
                    cur_demand <= cur_demand + didt;
                else if (ddelta < -dlim)
                    cur_demand <= cur_demand - didt;
                else
                    cur_demand <= spd_out;
            end
        end
    end

    // field weakening
    wire signed [15:0] vfb_f;
    wire signed [15:0] emf_out;
    sfl_leadlag u_bemf (
        .ref_clk(ref_clk),
        .rst(rst),
        .en(fld_tick),
        .x(arm_volts_fb),
        .gain(bemf_gain),
        .lead(bemf_lead),
        .lag_sh(bemf_lag),
        .y(vfb_f)
    );
    wire signed [15:0] verr = sat($signed({1'b0, max_volts}) - vfb_f);
    sfl_leadlag u_emf (
        .ref_clk(ref_clk),
        .rst(rst),
        .en(fld_tick),
        .x(verr),
        .gain(emf_gain),
        .lead(emf_lead),
        .lag_sh(emf_lag),
        .y(emf_out)
    );
    // only volts above the maximum produce weakening
    wire signed [15:0] fw_dem = emf_out[15] ? sat(-emf_out) : 16'h0000;
    wire signed [16:0] fw_raw = fld_setp - fw_dem;
    reg signed [15:0] fdem;
    always @* begin
        if (armv_fb)
            fdem = (fld_setp > `SFL_FULL) ? `SFL_FULL : fld_setp;
        else if (!fw_en)
            fdem = fld_setp;
        else if (fw_raw < $signed({1'b0, min_fld}))
            fdem = min_fld;
        else
            fdem = fw_raw[15:0];
    end

    // standby / quench timer, counted in field slots
    reg [15:0] qcnt;
    wire q_done = arm_quenched && (qcnt >= qdelay);
    always @(posedge ref_clk) begin
        if (rst) begin
            qcnt <= 16'h0000;
            fld_off <= 1'b1;
        end else begin
            if (!arm_quenched)
                qcnt <= 16'h0000;
            else if (fld_tick && !q_done)
                qcnt <= qcnt + 1'b1;
            fld_off <= !fld_en || (q_done && qmode);
        end
    end
    wire standby = q_done && !qmode;
    wire signed [15:0] fdem_q = standby ? (fdem >>> 1) : fdem;

    // field current loop
    wire signed [15:0] ferr = sat(fdem_q - fld_cur_fb);
    wire signed [32:0] fp_prod = ferr * $signed({1'b0, fld_kp});
    reg signed [23:0] fld_int;
    wire signed [40:0] fld_int_n = {{17{fld_int[23]}}, fld_int}
        + {{8{fp_prod[32]}}, fp_prod >>> fld_tau};
    wire signed [15:0] fld_p = sat($signed({{8{fp_prod[32]}}, fp_prod}) >>> 8);
    wire signed [15:0] fld_pi = sat(fld_p + $signed(fld_int[23:8]));
    wire [11:0] fld_u = fld_pi[15] ? 12'h000 :
        (fld_pi >= $signed(`SFL_FULL)) ? 12'hFFF : fld_pi[11:0];
    wire [7:0] vr_q = standby ? {1'b0, vratio[7:1]} : vratio;

    always @(posedge ref_clk) begin
        if (rst) begin
            fld_int <= 24'h000000;
            fld_angle <= 8'hFF;
            fld_fire <= 1'b0;
            arm_fire <= 1'b0;
            fld_oc_alarm <= 1'b0;
        end else begin
            if (fld_off)
                fld_int <= 24'h000000;
            else if (fld_tick)
                fld_int <= {sat(fld_int_n >>> 8), 8'h00};
            if (fld_tick) begin
                if (vmode)
                    fld_angle <= ~vr_q;
                else
                    fld_angle <= ~fld_u[11:4];
            end
            fld_fire <= fire[1] && !fld_off;
            arm_fire <= fire[0];
            fld_oc_alarm <= !vmode && (fld_cur_fb > $signed(oc_limit));
        end
    end

    // APB slave, one wait-free access phase
    wire setup = psel && !penable && !pready;
    wire wr = psel && penable && pready && pwrite;
    reg [31:0] rd;
    reg hit;
    always @* begin
        hit = 1'b1;
        rd = 32'h00000000;
        if (paddr == `SFL_CTRL)
            rd = {26'h0, ctrl};
        else if (paddr == `SFL_SPD_GAIN)
            rd = {11'h0, spd_tau, spd_kp};
        else if (paddr == `SFL_DIDT)
            rd = {16'h0, didt};
        else if (paddr == `SFL_FLD_GAIN)
            rd = {11'h0, fld_tau, fld_kp};
        else if (paddr == `SFL_FLD_SETP)
            rd = {16'h0, fld_setp};
        else if (paddr == `SFL_MIN_FLD)
            rd = {16'h0, min_fld};
        else if (paddr == `SFL_MAX_VOLTS)
            rd = {16'h0, max_volts};
        else if (paddr == `SFL_EMF)
            rd = {3'h0, emf_lag, emf_lead, emf_gain};
        else if (paddr == `SFL_BEMF_FBK)
            rd = {3'h0, bemf_lag, bemf_lead, bemf_gain};
        else if (paddr == `SFL_VRATIO)
            rd = {24'h0, vratio};
        else if (paddr == `SFL_QDELAY)
            rd = {16'h0, qdelay};
        else if (paddr == `SFL_OC_LIMIT)
            rd = {16'h0, oc_limit};
        else if (paddr == `SFL_ST_DEMAND)
            rd = {spd_i, cur_demand};
        else if (paddr == `SFL_ST_FIELD)
            rd = {6'h0, q_done, fld_off, fld_angle, fdem_q};
        else if (paddr == `SFL_ST_PERIOD)
            rd = {{32-PW{1'b0}}, period};
        else
            hit = 1'b0;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl <= `SFL_CTRL_RST;
            spd_kp <= `SFL_SPD_KP_RST;
            spd_tau <= `SFL_SPD_TAU_RST;
            didt <= `SFL_DIDT_RST;
            fld_kp <= `SFL_FLD_KP_RST;
            fld_tau <= `SFL_FLD_TAU_RST;
            fld_setp <= `SFL_FLD_SETP_RST;
            min_fld <= `SFL_MIN_FLD_RST;
            max_volts <= `SFL_MAX_VOLTS_RST;
            emf_gain <= `SFL_EMF_GAIN_RST;
            emf_lead <= `SFL_EMF_LEAD_RST;
            emf_lag <= `SFL_EMF_LAG_RST;
            bemf_gain <= `SFL_BEMF_GAIN_RST;
            bemf_lead <= `SFL_BEMF_LEAD_RST;
            bemf_lag <= `SFL_BEMF_LAG_RST;
            vratio <= `SFL_VRATIO_RST;
            qdelay <= `SFL_QDELAY_RST;
            oc_limit <= `SFL_OC_LIMIT_RST;
        end else begin
            pready <= setup;
            // error flag stands only with its ready pulse
            pslverr <= setup && !hit;
            if (setup)
                prdata <= pwrite ? 32'h00000000 : rd;
            if (wr) begin
                if (paddr == `SFL_CTRL)
                    ctrl <= pwdata[5:0];
                else if (paddr == `SFL_SPD_GAIN) begin
                    spd_kp <= pwdata[15:0];
                    spd_tau <= pwdata[20:16];
                end else if (paddr == `SFL_DIDT)
                    didt <= pwdata[15:0];
                else if (paddr == `SFL_FLD_GAIN) begin
                    fld_kp <= pwdata[15:0];
                    fld_tau <= pwdata[20:16];
                end else if (paddr == `SFL_FLD_SETP)
                    fld_setp <= pwdata[15:0];
                else if (paddr == `SFL_MIN_FLD)
                    min_fld <= pwdata[15:0];
                else if (paddr == `SFL_MAX_VOLTS)
                    max_volts <= pwdata[15:0];
                else if (paddr == `SFL_EMF) begin
                    emf_gain <= pwdata[15:0];
                    emf_lead <= pwdata[23:16];
                    emf_lag <= pwdata[28:24];
                end else if (paddr == `SFL_BEMF_FBK) begin
                    bemf_gain <= pwdata[15:0];
                    bemf_lead <= pwdata[23:16];
                    bemf_lag <= pwdata[28:24];
                end else if (paddr == `SFL_VRATIO)
                    vratio <= pwdata[7:0];
                else if (paddr == `SFL_QDELAY)
                    qdelay <= pwdata[15:0];
                else if (paddr == `SFL_OC_LIMIT)
                    oc_limit <= pwdata[15:0];
            end
        end
    end
endmodule

// [testbench/sfl_ctrl_monitor.sv]
/* Port checker of sfl_ctrl: bus handshake, firing cadence, demand step.
   Assumes the step limit and alarm level keep their reset values. */
`timescale 1ns/1ps
module sfl_ctrl_monitor (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire mains_zc,
    input wire signed [15:0] cur_demand,
    input wire signed [15:0] fld_cur_fb,
    input wire arm_fire,
    input wire fld_fire,
    input wire fld_oc_alarm
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    reg z1, z2, z3, z4, z5;
    reg [3:0] na, nf;
    wire zr = z4 & ~z5;
    // fire counts per mains cycle; window trails the slot restart by the
    // two cycles a fire decision takes to reach the pin
    always @(posedge ref_clk) begin
        z1 <= mains_zc;
        z2 <= z1;
        z3 <= z2;
        z4 <= z3;
        z5 <= z4;
        if (rst || zr) begin
            na <= 4'h0;
            nf <= 4'h0;
        end else begin
            na <= na + {3'h0, arm_fire};
            nf <= nf + {3'h0, fld_fire};
        end
    end
    AST_APB_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_UNMAPPED: assert property (psel && !penable |=> pslverr == (paddr > 8'h38))
        else $error("wrong error response");
    AST_DIDT_STEP: assert property (
        cur_demand - $past(cur_demand) <= 32'sh059A
        && $past(cur_demand) - cur_demand <= 32'sh059A)
        else $error("current demand step too large");
    AST_ARM_PULSE: assert property (arm_fire |=> !arm_fire)
        else $error("armature fire too long");
    AST_FLD_PULSE: assert property (fld_fire |=> !fld_fire)
        else $error("field fire too long");
    AST_ARM_COUNT: assert property (zr |-> na <= 4'h6)
        else $error("too many armature fires");
    AST_FLD_COUNT: assert property (zr |-> nf <= 4'h2)
        else $error("too many field fires");
    AST_OC_CAUSE: assert property (fld_oc_alarm |->
        $past(fld_cur_fb) > 16'sh1333 || $past(fld_cur_fb, 2) > 16'sh1333)
        else $error("alarm without overcurrent");
    AST_RST_QUIET: assert property ($past(rst) |-> !arm_fire && !fld_fire
        && cur_demand == 16'sh0000)
        else $error("outputs active after reset");
    cover property (arm_fire);
    cover property (pslverr);
    cover property (fld_oc_alarm);
endmodule

bind sfl_ctrl sfl_ctrl_monitor u_mon (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .mains_zc(mains_zc),
    .cur_demand(cur_demand), .fld_cur_fb(fld_cur_fb), .arm_fire(arm_fire),
    .fld_fire(fld_fire), .fld_oc_alarm(fld_oc_alarm));

// [testbench/sfl_plant_model.sv]
/* Far-side model: mains polarity and field bridge current.
   Assumes a 20 ns ref_clk; mains edges fall between clock edges. */
`timescale 1ns/1ps
module sfl_plant_model #(
    parameter HALF = 600
) (
    input wire ref_clk,
    input wire fld_fire,
    input wire signed [15:0] fld_level,
    output reg mains_zc,
    output reg signed [15:0] fld_cur_fb
);
    integer idle = 1000000;
    initial begin
        mains_zc = 1'b0;
        fld_cur_fb = 16'sh0000;
        #7;
        forever #(HALF * 20) mains_zc = ~mains_zc;
    end
    // field current collapses 2 * HALF clocks after the bridge stops firing
    always @(posedge ref_clk) begin
        idle <= fld_fire ? 0 : idle + 1;
        fld_cur_fb <= (idle < 2 * HALF) ? fld_level : 16'sh0000;
    end
endmodule

// [testbench/tb.sv]
/* Self-checking bench of sfl_ctrl with the mains and field model.
   Assumes the design, checker and model are compiled before it. */
`timescale 1ns/1ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin err_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, x); end end
module tb;
    localparam MP = 1200;
    typedef struct {logic [31:0] x; logic [31:0] m; logic e;} sfl_note_t;
    sfl_note_t notes[$];
    sfl_note_t nt;
    reg ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [7:0] paddr = 8'h00, arm_angle = 8'h40;
    reg [31:0] pwdata = 32'h0, rd, r;
    reg signed [15:0] speed_demand = 0, speed_fb = 0, tacho_fb = 0, enc_fb = 0;
    reg signed [15:0] arm_volts_fb = 0, fld_level = 0;
    reg arm_quenched = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, mains_zc, arm_fire, fld_fire, fld_oc_alarm;
    wire signed [15:0] cur_demand, fld_cur_fb;
    integer err_count = 0, num_checks = 0, seed = 97, na, nf, i;
    reg [31:0] dflt [0:11];

    always #10 ref_clk = ~ref_clk;

    sfl_ctrl uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mains_zc(mains_zc),
        .speed_demand(speed_demand), .speed_fb(speed_fb), .tacho_fb(tacho_fb),
        .enc_fb(enc_fb), .arm_volts_fb(arm_volts_fb), .fld_cur_fb(fld_cur_fb),
        .arm_quenched(arm_quenched), .arm_angle(arm_angle),
        .cur_demand(cur_demand), .arm_fire(arm_fire), .fld_fire(fld_fire),
        .fld_oc_alarm(fld_oc_alarm));

    sfl_plant_model #(.HALF(MP / 2)) u_plant (.ref_clk(ref_clk), .fld_fire(fld_fire),
        .fld_level(fld_level), .mains_zc(mains_zc), .fld_cur_fb(fld_cur_fb));

    // scoreboard: each bus answer against the oldest note
    always @(posedge ref_clk) begin
        if (pready === 1'b1 && psel && penable) begin
            nt = notes.pop_front();
            `CHK(prdata & nt.m, nt.x & nt.m)
            `CHK(pslverr, nt.e)
        end
    end

    task results;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    task apb(input [7:0] a, input w, input [31:0] d, x, m, input e);
        begin
            @(posedge ref_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            notes.push_back('{x, m, e});
            @(posedge ref_clk);
            penable <= 1'b1;
            do @(posedge ref_clk); while (pready !== 1'b1);
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(a, 1'b1, d, 32'h0, 32'hFFFFFFFF, 1'b0);
    endtask

    task rdx(input [7:0] a, input [31:0] x, m);
        apb(a, 1'b0, 32'h0, x, m, 1'b0);
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask

    task fires(output integer a, f);
        begin
            a = 0;
            f = 0;
            @(posedge mains_zc);
            repeat (MP) begin
                @(negedge ref_clk);
                a = a + arm_fire;
                f = f + fld_fire;
            end
        end
    endtask

    initial begin
        dflt = '{32'h25, 32'h60400, 32'h59A, 32'h30100, 32'h1000, 32'h19A,
                 32'h1000, 32'h90D01E0, 32'h3FF0010, 32'hE6, 32'h1F4, 32'h1333};
        cyc(3);
        rst <= 1'b0;
        for (i = 0; i < 12; i++)
            rdx(8'(i * 4), dflt[i], 32'hFFFFFFFF);
        apb(8'h3C, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(8'h40, 1'b1, 32'h5A5A, 32'h0, 32'hFFFFFFFF, 1'b1);
        repeat (4) begin
            r = $random(seed);
            wr(8'h04, r);
            rdx(8'h04, r & 32'h001FFFFF, 32'hFFFFFFFF);
        end
        wr(8'h04, 32'h00060400);
        r = $random(seed);
        arm_angle <= 8'h20 + {2'b00, r[5:0]};
        cyc(3 * MP);
        fires(na, nf);
        `CHK(na, 6)
        `CHK(nf, 2)
        wr(8'h38, 32'h0);
        rdx(8'h38, MP, 32'hFFFFFFFF);
        fld_level <= 16'sh1800;
        cyc(MP);
        @(negedge ref_clk);
        `CHK(fld_oc_alarm, 1'b1)
        wr(8'h00, 32'h2D);
        cyc(4);
        @(negedge ref_clk);
        `CHK(fld_oc_alarm, 1'b0)
        fires(na, nf);
        `CHK(nf, 2)
        wr(8'h28, 32'h2);
        wr(8'h00, 32'h3D);
        arm_quenched <= 1'b1;
        cyc(3 * MP);
        fires(na, nf);
        `CHK(nf, 0)
        rdx(8'h30, 32'h0, 32'hFFFF0000);
        wr(8'h00, 32'h2D);
        cyc(MP);
        fires(na, nf);
        `CHK(nf, 2)
        wr(8'h00, 32'h25);
        r = $random(seed);
        arm_quenched <= 1'b0;
        speed_demand <= 16'sh0800;
        tacho_fb <= 16'sh0800;
        speed_fb <= r[15:0];
        cyc(2 * MP);
        rdx(8'h30, 32'h0, 32'h0);
        `CHK(rd[31:16] != 16'h0 && !rd[31], 1'b1)
        @(negedge ref_clk);
        `CHK(cur_demand > 0, 1'b1)
        cyc(1);
        speed_demand <= 16'sh7FFF;
        tacho_fb <= 16'sh8000;
        cyc(MP);
        @(negedge ref_clk);
        `CHK(cur_demand[15], 1'b0)
        cyc(1);
        speed_demand <= 16'sh0000;
        tacho_fb <= 16'sh0000;
        wr(8'h20, 32'h03FF0010);
        wr(8'h00, 32'h27);
        arm_volts_fb <= 16'sh1400;
        cyc(3 * MP);
        rdx(8'h34, 32'h1000, 32'hFFFF);
        // fast weakening lead/lag so the floor is reached within the run
        wr(8'h1C, 32'h00FF01E0);
        wr(8'h00, 32'h25);
        cyc(5 * MP);
        rdx(8'h34, 32'h019A, 32'hFFFF);
        `CHK(rd[15:0] < 16'h1000 && rd[15:0] >= 16'h019A, 1'b1)
        results;
    end

    initial begin
        repeat (80000) @(posedge ref_clk);
        err_count++;
        results;
    end
endmodule
